// ### dv/board_model.sv
// Purpose: board side, makes both synth clocks and the status levels
// Assumes: synth clocks free running at eight and ten pclk periods
// Notes:   status levels move just after pclk edges, as on-chip logic would
`timescale 1ns/1ps
module board_model (
   input  wire logic pclk,
   input  wire logic presetn,
   output logic      synth_clk,
   output logic      second_synth_clk,
   output logic      aux_status_a,
   output logic      aux_status_b
);
   logic [3:0] cnt_ff;
   initial begin
      synth_clk = 1'b0;
      #13;
      forever #200 synth_clk = ~synth_clk;
   end
   initial begin
      second_synth_clk = 1'b0;
      #37;
      forever #250 second_synth_clk = ~second_synth_clk;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_ff <= 4'h0;
      else cnt_ff <= cnt_ff + 4'h1;
   end
   assign aux_status_a = cnt_ff[1];
   assign aux_status_b = cnt_ff[2] ^ cnt_ff[0];
endmodule // board_model

// ### dv/status_mux_checker.sv
// Purpose: port-level checks of the status pin clock mux
// Assumes: zero-wait apb, register shadows rebuilt from writes
// Notes:   shadows follow only mapped writes with pstrb[0] set
`timescale 1ns/1ps
module status_mux_checker
   import status_mux_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   input wire logic        aux_status_a,
   input wire logic        aux_status_b,
   input wire logic        aux_pin_a_out,
   input wire logic        aux_pin_a_oe_n,
   input wire logic        aux_pin_a_slow,
   input wire logic        aux_pin_b_out,
   input wire logic        aux_pin_b_oe_n,
   input wire logic        aux_pin_b_slow
);
   logic       wr_ok;
   logic [7:0] ctrl_ff;
   logic [7:0] div_a_ff;
   logic [3:0] slew_ff;
   logic [4:0] off_cnt_ff;
   logic [4:0] pre_cnt_ff;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign wr_ok = psel && penable && pwrite && pready && pstrb[0];
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= RST_CTRL;
         div_a_ff <= RST_DIV_A;
         slew_ff <= RST_SLEW;
      end else if (wr_ok) begin
         if (paddr == {IDX_CTRL, 2'b00}) ctrl_ff <= pwdata[7:0];
         if (paddr == {IDX_DIV_A, 2'b00}) div_a_ff <= pwdata[7:0];
         if (paddr == {IDX_SLEW, 2'b00}) slew_ff <= pwdata[3:0];
      end
   end
   // any write with pstrb[0] set restarts both, so pipeline drain is never mistaken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_cnt_ff <= 5'h00;
      end else if (wr_ok || ctrl_ff[1:0] != 2'h0 || div_a_ff != 8'h00) begin
         off_cnt_ff <= 5'h00;
      end else if (off_cnt_ff != 5'h1F) begin
         off_cnt_ff <= off_cnt_ff + 5'h01;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_ff <= 5'h00;
      end else if (wr_ok || ctrl_ff[1:0] != 2'h0 || ctrl_ff[5:4] != PRE_OFF) begin
         pre_cnt_ff <= 5'h00;
      end else if (pre_cnt_ff != 5'h1F) begin
         pre_cnt_ff <= pre_cnt_ff + 5'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_a_off; ctrl_ff[1:0] == 2'h3 |=> aux_pin_a_oe_n && !aux_pin_a_out; endproperty
   a_a_off: assert property (p_a_off) else $error("pin a not disabled");
   property p_b_off; ctrl_ff[3:2] == 2'h3 |=> aux_pin_b_oe_n && !aux_pin_b_out; endproperty
   a_b_off: assert property (p_b_off) else $error("pin b not disabled");
   property p_a_stat;
      ctrl_ff[1:0] == 2'h2 |=> !aux_pin_a_oe_n && aux_pin_a_out == $past(aux_status_a);
   endproperty
   a_a_stat: assert property (p_a_stat) else $error("pin a status wrong");
   property p_b_stat;
      ctrl_ff[3:2] == 2'h2 |=> !aux_pin_b_oe_n && aux_pin_b_out == $past(aux_status_b);
   endproperty
   a_b_stat: assert property (p_b_stat) else $error("pin b status wrong");
   property p_a_slew; 1'b1 |=> aux_pin_a_slow == ($past(slew_ff[1:0]) == EDGE_SLOW); endproperty
   a_a_slew: assert property (p_a_slew) else $error("pin a edge rate wrong");
   property p_b_slew; 1'b1 |=> aux_pin_b_slow == ($past(slew_ff[3:2]) == EDGE_SLOW); endproperty
   a_b_slew: assert property (p_b_slew) else $error("pin b edge rate wrong");
   property p_div_off; off_cnt_ff >= 5'h10 |-> !aux_pin_a_out; endproperty
   a_div_off: assert property (p_div_off) else $error("divider off but clock runs");
   property p_pre_off; pre_cnt_ff == 5'h1F |-> $stable(aux_pin_a_out); endproperty
   a_pre_off: assert property (p_pre_off) else $error("prescaler off but clock runs");
endmodule // status_mux_checker

bind status_pin_cmos_clock_mux status_mux_checker status_mux_checker_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
   .aux_status_a(aux_status_a), .aux_status_b(aux_status_b),
   .aux_pin_a_out(aux_pin_a_out), .aux_pin_a_oe_n(aux_pin_a_oe_n),
   .aux_pin_a_slow(aux_pin_a_slow), .aux_pin_b_out(aux_pin_b_out),
   .aux_pin_b_oe_n(aux_pin_b_oe_n), .aux_pin_b_slow(aux_pin_b_slow));

// ### dv/testbench.sv
// Purpose: self-checking bench of the status pin clock mux
// Assumes: zero-wait apb slave, pstrb always full
// Notes:   pin periods counted in pclk cycles between rising edges
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench
   import status_mux_pkg::*;
;
   localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
   localparam logic [7:0] A_DIV_A = {IDX_DIV_A, 2'b00};
   localparam logic [7:0] A_DIV_B = {IDX_DIV_B, 2'b00};
   localparam logic [7:0] A_SRC = {IDX_SRC, 2'b00};
   localparam logic [7:0] A_SLEW = {IDX_SLEW, 2'b00};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic        synth_clk, second_synth_clk, aux_status_a, aux_status_b;
   logic        aux_pin_a_out, aux_pin_a_oe_n, aux_pin_a_slow;
   logic        aux_pin_b_out, aux_pin_b_oe_n, aux_pin_b_slow;
   int          errors, comparisons, cycles;
   int unsigned got;
   logic [31:0] q;
   logic        err;
   status_pin_cmos_clock_mux status_pin_cmos_clock_mux_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .synth_clk(synth_clk), .second_synth_clk(second_synth_clk),
      .aux_status_a(aux_status_a), .aux_status_b(aux_status_b),
      .aux_pin_a_out(aux_pin_a_out), .aux_pin_a_oe_n(aux_pin_a_oe_n),
      .aux_pin_a_slow(aux_pin_a_slow), .aux_pin_b_out(aux_pin_b_out),
      .aux_pin_b_oe_n(aux_pin_b_oe_n), .aux_pin_b_slow(aux_pin_b_slow));
   board_model board_model_i (.pclk(pclk), .presetn(presetn), .synth_clk(synth_clk),
      .second_synth_clk(second_synth_clk), .aux_status_a(aux_status_a),
      .aux_status_b(aux_status_b));
   ////////////////////////////////////////////////////////////////////////
   // no local limit: a missing pready is caught by the run's cycle ceiling
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= {24'h000000, d};
         @(posedge pclk);
         penable <= 1'b1;
         do begin
            @(posedge pclk);
         end while (pready !== 1'b1);
         q = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      `CHK(q, {24'h000000, e})
   endtask
   // skips the first period, which may be cut short by the new setting
   task automatic measure(input logic pin_b, input int unsigned e);
      logic prv, cur;
      int unsigned rises, n;
      begin
         prv = 1'b1;
         rises = 0;
         got = 0;
         for (n = 0; n < 4 * e + 400 && rises < 3; n++) begin
            @(posedge pclk);
            #1;
            cur = pin_b ? aux_pin_b_out : aux_pin_a_out;
            if (rises == 2) got++;
            if (cur === 1'b1 && prv === 1'b0) rises++;
            prv = cur;
         end
         `CHK(got, e)
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd(A_CTRL, RST_CTRL);
      rd(A_DIV_A, 8'h00);
      rd(A_SLEW, 8'h00);
      apb(1'b1, A_DIV_A, 8'h5A);
      rd(A_DIV_A, 8'h5A);
      rd(8'hFC, 8'h00);
      `CHK(err, 1'b1)
      $display("t_regs done");
   endtask
   task automatic t_slew;
      logic [3:0] codes [4];
      int i;
      begin
         codes = '{4'h8, 4'h2, 4'hA, 4'h0};
         for (i = 0; i < 4; i++) begin
            apb(1'b1, A_SLEW, {4'h0, codes[i]});
            rd(A_SLEW, {4'h0, codes[i]});
            `CHK({aux_pin_b_slow, aux_pin_a_slow}, {codes[i][3:2] == EDGE_SLOW, codes[i][1:0] == EDGE_SLOW})
         end
         $display("t_slew done");
      end
   endtask
   task automatic t_off;
      logic v;
      begin
         apb(1'b1, A_DIV_A, 8'h00);
         apb(1'b1, A_CTRL, {2'b00, PRE_DIV4, 2'h2, 2'h0});
         repeat (20) @(posedge pclk);
         `CHK(aux_pin_a_out, 1'b0)
         apb(1'b1, A_CTRL, {2'b00, PRE_OFF, 2'h2, 2'h0});
         apb(1'b1, A_DIV_A, 8'h01);
         repeat (20) @(posedge pclk);
         v = aux_pin_a_out;
         repeat (40) @(posedge pclk);
         `CHK(aux_pin_a_out, v)
         apb(1'b1, A_CTRL, 8'h0F);
         repeat (3) @(posedge pclk);
         `CHK({aux_pin_a_oe_n, aux_pin_b_oe_n, aux_pin_a_out, aux_pin_b_out}, 4'hC)
         $display("t_off done");
      end
   endtask
   task automatic t_divs;
      logic [7:0] code [4];
      logic [1:0] pre [4];
      int unsigned ratio [4];
      int i;
      begin
         code = '{8'h01, 8'h05, 8'h06, 8'hFF};
         pre = '{PRE_DIV4, PRE_DIV4, PRE_DIV5, PRE_DIV4};
         ratio = '{4 * 6, 4 * 6, 5 * 7, 4 * 256};
         for (i = 0; i < 4; i++) begin
            apb(1'b1, A_DIV_A, code[i]);
            apb(1'b1, A_CTRL, {2'b00, pre[i], 2'h2, 2'h0});
            measure(1'b0, ratio[i] * 8);
         end
         $display("t_divs done");
      end
   endtask
   task automatic t_src;
      apb(1'b1, A_DIV_A, 8'h01);
      apb(1'b1, A_DIV_B, 8'h06);
      apb(1'b1, A_SRC, 8'h01);
      rd(A_SRC, 8'h01);
      apb(1'b1, A_CTRL, {2'b00, PRE_DIV4, 2'h0, 2'h1});
      measure(1'b0, 4 * 7 * 10);
      measure(1'b1, 4 * 6 * 10);
      apb(1'b1, A_SRC, 8'h00);
      measure(1'b0, 4 * 7 * 8);
      // swapped routing: pin b from divider b, pin a from divider a
      apb(1'b1, A_CTRL, {2'b00, PRE_DIV4, 2'h1, 2'h0});
      measure(1'b1, 4 * 7 * 8);
      measure(1'b0, 4 * 6 * 8);
      $display("t_src done");
   endtask
   task automatic stop_test;
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // bounds the whole run, well above the longest divider measurement
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 80000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      errors = 0;
      comparisons = 0;
      cycles = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_slew();
      t_off();
      t_divs();
      t_src();
      stop_test();
   end
endmodule // testbench

// ### rtl/cmos_div_if.sv
// Purpose: link between the control logic and one cmos output divider
// Assumes: tick is a one-cycle enable on pclk
// Notes:   ratio of zero stops the divider
`timescale 1ns/1ps
interface cmos_div_if;
   logic       tick;
   logic [8:0] ratio;
   logic       div_clk;
   logic       active;

   modport ctrl (output tick, output ratio, input div_clk, input active);
   modport div  (input tick, input ratio, output div_clk, output active);
endinterface

// ### rtl/cmos_divider.sv
// Purpose: 8-bit cmos output divider driven by pre-divider ticks
// Assumes: ratio is 6..256 or 0 for off
// Notes:   odd ratios give the longer half high
`timescale 1ns/1ps
module cmos_divider
   import status_mux_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   cmos_div_if.div   dif
);

   logic [7:0] count_ff;
   logic       clk_ff;
   logic [8:0] half;
   logic [8:0] last;

   assign half = (dif.ratio + 9'h001) >> 1;
   assign last = dif.ratio - 9'h001;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= 8'h00;
      end else if (dif.ratio == 9'h000) begin
         count_ff <= 8'h00;
      end else if (dif.tick) begin
         // a ratio shrunk below the count restarts on the next tick
         if ({1'b0, count_ff} >= last)
            count_ff <= 8'h00;
         else
            count_ff <= count_ff + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         clk_ff <= 1'b0;
      else
         clk_ff <= (dif.ratio != 9'h000) && ({1'b0, count_ff} < half);
   end

   assign dif.div_clk = clk_ff;
   assign dif.active  = (dif.ratio != 9'h000);

endmodule // cmos_divider

// ### rtl/status_mux_pkg.sv
// Purpose: shared constants, types and decoders of the status pin clock mux
// Assumes: register index times four is the apb byte address
// Notes:   widths and codes are fixed, nothing here is tunable
package status_mux_pkg;

   // register indices, byte address = index * 4
   localparam logic [5:0] IDX_CTRL   = 6'h2D;
   localparam logic [5:0] IDX_DIV_A  = 6'h2E;
   localparam logic [5:0] IDX_DIV_B  = 6'h2F;
   localparam logic [5:0] IDX_SRC    = 6'h30;
   localparam logic [5:0] IDX_SLEW   = 6'h31;
   localparam logic [5:0] IDX_STATE  = 6'h32;

   // reset values
   localparam logic [7:0] RST_CTRL   = 8'h0A;
   localparam logic [7:0] RST_DIV_A  = 8'h00;
   localparam logic [7:0] RST_DIV_B  = 8'h00;
   localparam logic       RST_SRC    = 1'b0;
   localparam logic [3:0] RST_SLEW   = 4'h0;

   // field positions
   localparam int CTRL_PRE_LSB   = 4;
   localparam int CTRL_B_SEL_LSB = 2;
   localparam int CTRL_A_SEL_LSB = 0;
   localparam int SLEW_B_LSB     = 2;
   localparam int SLEW_A_LSB     = 0;
   localparam int ST_PIN_A       = 0;
   localparam int ST_PIN_B       = 1;
   localparam int ST_DIV_A_ON    = 2;
   localparam int ST_DIV_B_ON    = 3;
   localparam int ST_PRE_ON      = 4;
   localparam int ST_SRC_SECOND  = 5;

   // pre-divider codes and ratios
   localparam logic [1:0] PRE_OFF    = 2'h0;
   localparam logic [1:0] PRE_DIV4   = 2'h1;
   localparam logic [1:0] PRE_DIV5   = 2'h2;
   localparam logic [2:0] PRE_RATIO4 = 3'h4;
   localparam logic [2:0] PRE_RATIO5 = 3'h5;

   // cmos divider codes
   localparam logic [7:0] DIV_OFF_CODE  = 8'h00;
   localparam logic [7:0] DIV_MIN_CODE  = 8'h06;
   localparam logic [8:0] DIV_MIN_RATIO = 9'h006;

   // edge-rate codes
   localparam logic [1:0] EDGE_SLOW  = 2'h2;

   typedef enum logic [1:0] {
      PIN_DIV_A  = 2'b00,
      PIN_DIV_B  = 2'b01,
      PIN_STATUS = 2'b10,
      PIN_OFF    = 2'b11
   } pin_src_t;

   // 0 means no pre-divided clock; reserved code 3 also yields none
   function automatic logic [2:0] prescale_ratio(input logic [1:0] code);
      case (code)
         PRE_DIV4: prescale_ratio = PRE_RATIO4;
         PRE_DIV5: prescale_ratio = PRE_RATIO5;
         default:  prescale_ratio = 3'h0;
      endcase
   endfunction

   // 0 means divider disabled
   function automatic logic [8:0] cmos_ratio(input logic [7:0] code);
      if (code == DIV_OFF_CODE)
         cmos_ratio = 9'h000;
      else if (code < DIV_MIN_CODE)
         cmos_ratio = DIV_MIN_RATIO;
      else
         cmos_ratio = {1'b0, code} + 9'h001;
   endfunction

   function automatic pin_src_t pin_src(input logic [1:0] code);
      pin_src = pin_src_t'(code);
   endfunction

endpackage

// ### rtl/status_pin_cmos_clock_mux.sv
// Purpose: apb-configured clock/status mux for two auxiliary status pins
// Assumes: synth clocks run below a quarter of pclk; status inputs are on pclk
// Notes:   all divided clocks are pclk-sampled, so edges carry pclk jitter
// Summary of operation
// - pre-divider select: 0 off, 1 divide by 4, 2 divide by 5, 3 reserved
// - cmos dividers fed by primary or second_synth pre-divided clock
// - either pin may take its clock from either cmos divider
// - pin b source: 0 divider a, 1 divider b, 2 status, 3 off
// - pin a source: same encoding as pin b, resets to status
// - divider a: 0 off, 1..5 divide by 6, else code plus one
// - pin b edge rate: 0 fast, 2 slow, 1 and 3 reserved
// - pin a edge rate: 0 fast, 2 slow, 1 and 3 reserved
`timescale 1ns/1ps
module status_pin_cmos_clock_mux
   import status_mux_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        synth_clk,
   input  wire logic        second_synth_clk,
   input  wire logic        aux_status_a,
   input  wire logic        aux_status_b,
   output logic             aux_pin_a_out,
   output logic             aux_pin_a_oe_n,
   output logic             aux_pin_a_slow,
   output logic             aux_pin_b_out,
   output logic             aux_pin_b_oe_n,
   output logic             aux_pin_b_slow
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [7:0]  cmos_divider_control_ff;
   logic [7:0]  cmos_divider_a_ratio_ff;
   logic [7:0]  cmos_divider_b_ratio_ff;
   logic        cmos_source_select_ff;
   logic [3:0]  aux_pin_edge_rate_ff;
   logic [31:0] prdata_ff;

   logic [1:0]  synth_sync_ff;
   logic [1:0]  second_sync_ff;
   logic        synth_prev_ff;
   logic        second_prev_ff;
   logic        synth_rise;
   logic        second_rise;
   logic        src_rise;

   logic [2:0]  pre_count_ff;
   logic        pre_tick_ff;
   logic [2:0]  pre_ratio;

   logic        pin_a_out_ff;
   logic        pin_a_oe_n_ff;
   logic        pin_a_slow_ff;
   logic        pin_b_out_ff;
   logic        pin_b_oe_n_ff;
   logic        pin_b_slow_ff;

   logic        setup;
   logic        access;
   logic        wr_en;
   logic        addr_ok;
   logic        sel_ctrl;
   logic        sel_div_a;
   logic        sel_div_b;
   logic        sel_src;
   logic        sel_slew;
   logic        sel_state;
   logic [31:0] rd_mux;
   logic [7:0]  state_word;

   logic [1:0]  div_clk;
   logic [1:0]  div_active;
   logic [7:0]  div_code [2];

   logic        nxt_pin_a_out;
   logic        nxt_pin_a_oe_n;
   logic        nxt_pin_b_out;
   logic        nxt_pin_b_oe_n;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode

   // true when the address hits the given register word
   function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
      hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
   endfunction

   assign setup     = psel && !penable;
   assign access    = psel && penable;
   assign sel_ctrl  = hit(paddr, IDX_CTRL);
   assign sel_div_a = hit(paddr, IDX_DIV_A);
   assign sel_div_b = hit(paddr, IDX_DIV_B);
   assign sel_src   = hit(paddr, IDX_SRC);
   assign sel_slew  = hit(paddr, IDX_SLEW);
   assign sel_state = hit(paddr, IDX_STATE);
   assign addr_ok   = sel_ctrl || sel_div_a || sel_div_b || sel_src || sel_slew || sel_state;

   // only the low byte lane carries register data
   assign wr_en     = access && pwrite && addr_ok && pstrb[0];

   // zero wait states; errors only for unmapped or unaligned words
   assign pready    = 1'b1;
   assign pslverr   = access && !addr_ok;

   ////////////////////////////////////////////////////////////////////////////
   // registers

   // reserved bits 7:6 are kept as written and read back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cmos_divider_control_ff <= RST_CTRL;
      else if (wr_en && sel_ctrl)
         cmos_divider_control_ff <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cmos_divider_a_ratio_ff <= RST_DIV_A;
      else if (wr_en && sel_div_a)
         cmos_divider_a_ratio_ff <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cmos_divider_b_ratio_ff <= RST_DIV_B;
      else if (wr_en && sel_div_b)
         cmos_divider_b_ratio_ff <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cmos_source_select_ff <= RST_SRC;
      else if (wr_en && sel_src)
         cmos_source_select_ff <= pwdata[0];
   end

   // upper nibble is not stored and reads as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         aux_pin_edge_rate_ff <= RST_SLEW;
      else if (wr_en && sel_slew)
         aux_pin_edge_rate_ff <= pwdata[3:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path

   always_comb begin
      state_word                = 8'h00;
      state_word[ST_PIN_A]      = pin_a_out_ff;
      state_word[ST_PIN_B]      = pin_b_out_ff;
      state_word[ST_DIV_A_ON]   = div_active[0];
      state_word[ST_DIV_B_ON]   = div_active[1];
      state_word[ST_PRE_ON]     = (pre_ratio != 3'h0);
      state_word[ST_SRC_SECOND] = cmos_source_select_ff;
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_ctrl)
         rd_mux = {24'h000000, cmos_divider_control_ff};
      else if (sel_div_a)
         rd_mux = {24'h000000, cmos_divider_a_ratio_ff};
      else if (sel_div_b)
         rd_mux = {24'h000000, cmos_divider_b_ratio_ff};
      else if (sel_src)
         rd_mux = {31'h0000_0000, cmos_source_select_ff};
      else if (sel_slew)
         rd_mux = {28'h000_0000, aux_pin_edge_rate_ff};
      else if (sel_state)
         rd_mux = {24'h000000, state_word};
   end

   // captured in the setup cycle so read data is a flop in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata_ff <= 32'h0000_0000;
      else if (setup && !pwrite)
         prdata_ff <= rd_mux;
   end

   assign prdata = prdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // synth clock sampling

   // first stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         synth_sync_ff  <= 2'b00;
         second_sync_ff <= 2'b00;
      end else begin
         synth_sync_ff  <= {synth_sync_ff[0], synth_clk};
         second_sync_ff <= {second_sync_ff[0], second_synth_clk};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         synth_prev_ff  <= 1'b0;
         second_prev_ff <= 1'b0;
      end else begin
         synth_prev_ff  <= synth_sync_ff[1];
         second_prev_ff <= second_sync_ff[1];
      end
   end

   assign synth_rise  = synth_sync_ff[1] && !synth_prev_ff;
   assign second_rise = second_sync_ff[1] && !second_prev_ff;
   assign src_rise    = cmos_source_select_ff ? second_rise : synth_rise;

   ////////////////////////////////////////////////////////////////////////////
   // pre-divider

   assign pre_ratio = prescale_ratio(cmos_divider_control_ff[CTRL_PRE_LSB +: 2]);

   // reserved code 3 behaves as disabled: no ticks reach the dividers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_count_ff <= 3'h0;
         pre_tick_ff  <= 1'b0;
      end else if (pre_ratio == 3'h0) begin
         pre_count_ff <= 3'h0;
         pre_tick_ff  <= 1'b0;
      end else if (src_rise) begin
         if (pre_count_ff >= pre_ratio - 3'h1) begin
            pre_count_ff <= 3'h0;
            pre_tick_ff  <= 1'b1;
         end else begin
            pre_count_ff <= pre_count_ff + 3'h1;
            pre_tick_ff  <= 1'b0;
         end
      end else begin
         pre_tick_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cmos dividers

   assign div_code[0] = cmos_divider_a_ratio_ff;
   assign div_code[1] = cmos_divider_b_ratio_ff;

   generate
      for (genvar i = 0; i < 2; i++) begin : g_div
         cmos_div_if dif ();

         assign dif.tick      = pre_tick_ff;
         assign dif.ratio     = cmos_ratio(div_code[i]);
         assign div_clk[i]    = dif.div_clk;
         assign div_active[i] = dif.active;

         cmos_divider u_div (
            .pclk    (pclk),
            .presetn (presetn),
            .dif     (dif.div)
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // pin source muxes

   // disabled pins are released; output forced low too
   always_comb begin
      nxt_pin_a_out  = 1'b0;
      nxt_pin_a_oe_n = 1'b0;
      case (pin_src(cmos_divider_control_ff[CTRL_A_SEL_LSB +: 2]))
         PIN_DIV_A:  nxt_pin_a_out  = div_clk[0];
         PIN_DIV_B:  nxt_pin_a_out  = div_clk[1];
         PIN_STATUS: nxt_pin_a_out  = aux_status_a;
         PIN_OFF:    nxt_pin_a_oe_n = 1'b1;
         default:    nxt_pin_a_oe_n = 1'b1;
      endcase
   end

   always_comb begin
      nxt_pin_b_out  = 1'b0;
      nxt_pin_b_oe_n = 1'b0;
      case (pin_src(cmos_divider_control_ff[CTRL_B_SEL_LSB +: 2]))
         PIN_DIV_A:  nxt_pin_b_out  = div_clk[0];
         PIN_DIV_B:  nxt_pin_b_out  = div_clk[1];
         PIN_STATUS: nxt_pin_b_out  = aux_status_b;
         PIN_OFF:    nxt_pin_b_oe_n = 1'b1;
         default:    nxt_pin_b_oe_n = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_a_out_ff  <= 1'b0;
         pin_a_oe_n_ff <= 1'b0;
         pin_b_out_ff  <= 1'b0;
         pin_b_oe_n_ff <= 1'b0;
      end else begin
         pin_a_out_ff  <= nxt_pin_a_out;
         pin_a_oe_n_ff <= nxt_pin_a_oe_n;
         pin_b_out_ff  <= nxt_pin_b_out;
         pin_b_oe_n_ff <= nxt_pin_b_oe_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // edge-rate controls

   // reserved codes fall back to the fast edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_a_slow_ff <= 1'b0;
         pin_b_slow_ff <= 1'b0;
      end else begin
         pin_a_slow_ff <= (aux_pin_edge_rate_ff[SLEW_A_LSB +: 2] == EDGE_SLOW);
         pin_b_slow_ff <= (aux_pin_edge_rate_ff[SLEW_B_LSB +: 2] == EDGE_SLOW);
      end
   end

   assign aux_pin_a_out  = pin_a_out_ff;
   assign aux_pin_a_oe_n = pin_a_oe_n_ff;
   assign aux_pin_a_slow = pin_a_slow_ff;
   assign aux_pin_b_out  = pin_b_out_ff;
   assign aux_pin_b_oe_n = pin_b_oe_n_ff;
   assign aux_pin_b_slow = pin_b_slow_ff;

endmodule // status_pin_cmos_clock_mux
